// *** design/rivm_prio_enc.sv ***
`timescale 1ns/1ns
// Picks the highest set index of a request vector.
module rivm_prio_enc
   import rivm_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic [W-1:0] req,
   output logic any,
   output logic [$clog2(W)-1:0] idx
);
   // Elaboration check: a single input leaves no index to encode.
   if (W < 2) begin : g_bad_width
      $error("rivm_prio_enc needs at least two inputs.");
   end

   // Later loop iterations win, so the highest index takes the slot.
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = 0; i < W; i++) begin
         if (req[i]) begin
            any = 1'b1;
            idx = i[$clog2(W)-1:0];
         end
      end
   end
endmodule

// *** design/rivm_top.sv ***
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: Successful full erase writes unsecured security byte.
// RULE_02: All reset sources use one unmaskable vector.
// RULE_03: Watchdog reset needs nonzero rate field.
// RULE_04: Oscillator monitor reset needs both enables.
// RULE_05: Higher vector offset wins arbitration.
// RULE_06: Vector equals software base plus offset.
// RULE_07: Opcode traps ignore every mask.
// RULE_08: Software and system calls ignore masks.
// RULE_09: Timer channels I-masked, enabled per channel.
// RULE_10: Abort-done request I-masked, locally enabled.
// RULE_11: Serial port shares one vector, five enables.
// RULE_12: Battery monitor needs high or low enable.
// RULE_13: Gate driver combines three fault enables.
// RULE_14: No reserved vector, no empty request.
module rivm_top
   import rivm_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Reset request inputs, all from logic on CLK.
   input wire logic POR_REQ,
   input wire logic LOW_VOLTAGE_RESET_SOURCE,
   input wire logic EXT_PIN_RESET_REQ,
   input wire logic OSC_FAIL,
   input wire logic WATCHDOG_TIMEOUT,
   // Core side.
   input wire logic TRAP1_REQ,
   input wire logic TRAP2_REQ,
   input wire logic SOFT_INT_REQ,
   input wire logic CALL_INSTR_REQ,
   input wire logic I_MASK,
   input wire logic IRQ_ACK,
   // Peripheral raw flags.
   input wire logic [3:0] TIM_CH_FLAG,
   input wire logic ABORT_DONE_FLAG,
   input wire logic [4:0] SERIAL0_FLAG,
   input wire logic [4:0] SERIAL1_FLAG,
   input wire logic BAT_HIGH_FLAG,
   input wire logic BAT_LOW_FLAG,
   input wire logic [2:0] DRIVER_FLAG,
   // Flash erase result.
   input wire logic ERASE_DONE,
   input wire logic ERASE_OK,
   // Outputs.
   output logic RESET_REQ,
   output logic [19:0] RESET_VEC,
   output logic SEC_PROG,
   output logic [1:0] SEC_VALUE,
   output logic SECURED,
   output logic IRQ_REQ,
   output logic [23:0] IRQ_VECTOR,
   output logic EVENT_IRQ
);
   ////////////////////////////////////////////////////////////////////////
   // State.
   typedef struct packed {
      logic [23:0] vecbase;       // Relocatable vector base.
      logic [2:0] wd_rate;        // Watchdog rate field, zero is off.
      logic osc_en;               // Oscillator enable bit.
      logic osc_mon_rst_en;       // Oscillator monitor reset enable.
      logic [21:0] irq_en;        // Per-source local enables.
      logic [NEV-1:0] ev_stat;    // Sticky event bits.
      logic [NEV-1:0] ev_en;      // Event interrupt enables.
      logic secured;              // Security state.
      logic sec_prog;             // One-cycle programming strobe.
      logic rst_req;              // Registered reset request.
      logic irq_req;              // Registered request to the core.
      logic [23:0] irq_vec;       // Registered vector address.
      logic [31:0] prdata;        // Read data.
   } rivm_state_t;

   rivm_state_t st_ff;
   rivm_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // Local enable field positions in irq_en.
   // [3:0] timer channels 0..3, [4] abort done, [9:5] serial zero
   // (tx empty, tx complete, rx full, idle, rx edge), [14:10] serial one,
   // [15] battery high, [16] battery low, [19:17] gate driver
   // (overcurrent, high side drain, low side level), [21:20] spare.

   logic [NSRC-1:0] pend;  // Requests after masking.
   logic any_pend;         // Some request is pending.
   logic [3:0] win;        // Index of the winning source.
   logic [8:0] win_ofs;    // Offset of the winner.
   logic apb_wr;           // Write access phase.
   logic apb_rd;           // Read setup phase.
   logic addr_ok;          // Address is mapped.

   ////////////////////////////////////////////////////////////////////////
   // Request masking. Traps and instruction calls have no mask at all.
   always_comb begin
      pend = '0;
      pend[S_TRAP1] = TRAP1_REQ; // [RULE_07]
      pend[S_TRAP2] = TRAP2_REQ; // [RULE_07]
      pend[S_SOFT_INT] = SOFT_INT_REQ; // [RULE_08]
      pend[S_CALL] = CALL_INSTR_REQ; // [RULE_08]
      for (int c = 0; c < 4; c++) begin
         // Channel c sits at index S_TIM_C0 minus c.
         pend[S_TIM_C0 - c] = TIM_CH_FLAG[c] & st_ff.irq_en[c]
                              & ~I_MASK; // [RULE_09]
      end
      pend[S_ADC_AD] = ABORT_DONE_FLAG & st_ff.irq_en[4]
                       & ~I_MASK; // [RULE_10]
      pend[S_SERIAL0] = (|(SERIAL0_FLAG & st_ff.irq_en[9:5]))
                        & ~I_MASK; // [RULE_11]
      pend[S_SERIAL1] = (|(SERIAL1_FLAG & st_ff.irq_en[14:10]))
                        & ~I_MASK; // [RULE_11]
      pend[S_BATMON] = ((BAT_HIGH_FLAG & st_ff.irq_en[15])
                     | (BAT_LOW_FLAG & st_ff.irq_en[16]))
                     & ~I_MASK; // [RULE_12]
      pend[S_DRV_LIM] = (|(DRIVER_FLAG & st_ff.irq_en[19:17]))
                        & ~I_MASK; // [RULE_13]
   end

   // The highest index is the highest offset.
   rivm_prio_enc #(
      .W(NSRC)
   ) u_prio (
      .req(pend),
      .any(any_pend),
      .idx(win)
   ); // [RULE_05]

   ////////////////////////////////////////////////////////////////////////
   // Offset lookup; unused indices never win since they are never set.
   always_comb begin
      win_ofs = OFS_DRV_LIM;
      case (win)
         4'd12: win_ofs = OFS_TRAP1;
         4'd11: win_ofs = OFS_TRAP2;
         4'd10: win_ofs = OFS_SOFT_INT;
         4'd9: win_ofs = OFS_CALL;
         4'd8: win_ofs = OFS_TIM_C0;
         4'd7: win_ofs = OFS_TIM_C0 - OFS_TIM_STEP;
         4'd6: win_ofs = OFS_TIM_C0 - 9'(2 * OFS_TIM_STEP);
         4'd5: win_ofs = OFS_TIM_C0 - 9'(3 * OFS_TIM_STEP);
         4'd4: win_ofs = OFS_SERIAL0;
         4'd3: win_ofs = OFS_SERIAL1;
         4'd2: win_ofs = OFS_ADC_AD;
         4'd1: win_ofs = OFS_BATMON;
         default: win_ofs = OFS_DRV_LIM; // [RULE_14]
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode. The slave answers in the access cycle, no wait states.
   assign apb_wr = PSEL & PENABLE & PWRITE;
   assign apb_rd = PSEL & ~PENABLE & ~PWRITE;
   always_comb begin
      if (PADDR == ADDR_VECBASE) begin
         addr_ok = 1'b1;
      end else if (PADDR == ADDR_RSTCFG) begin
         addr_ok = 1'b1;
      end else if (PADDR == ADDR_IRQEN) begin
         addr_ok = 1'b1;
      end else if (PADDR == ADDR_PEND || PADDR == ADDR_VECTOR) begin
         addr_ok = 1'b1;
      end else if (PADDR == ADDR_EVSTAT || PADDR == ADDR_EVEN) begin
         addr_ok = 1'b1;
      end else if (PADDR == ADDR_EVCLR || PADDR == ADDR_SECST) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      logic [NEV-1:0] ev_set;
      ev_set = '0;
      nxt_st = st_ff;
      nxt_st.sec_prog = 1'b0;
      // Register writes.
      if (apb_wr) begin
         if (PADDR == ADDR_VECBASE) begin
            // Low nine bits hold the offset, so base is aligned.
            nxt_st.vecbase = {PWDATA[23:9], 9'h000}; // [RULE_06]
         end else if (PADDR == ADDR_RSTCFG) begin
            nxt_st.wd_rate = PWDATA[2:0];
            nxt_st.osc_en = PWDATA[3];
            nxt_st.osc_mon_rst_en = PWDATA[4];
         end else if (PADDR == ADDR_IRQEN) begin
            nxt_st.irq_en = PWDATA[21:0];
         end else if (PADDR == ADDR_EVEN) begin
            nxt_st.ev_en = PWDATA[NEV-1:0];
         end else if (PADDR == ADDR_EVCLR) begin
            nxt_st.ev_stat = st_ff.ev_stat & ~PWDATA[NEV-1:0];
         end
      end
      // Erase success unsecures and programs the byte.
      if (ERASE_DONE && ERASE_OK) begin
         nxt_st.secured = 1'b0; // [RULE_01]
         nxt_st.sec_prog = 1'b1; // [RULE_01]
         ev_set[EV_ERASE_OK] = 1'b1;
      end
      // Resets: none is masked; locally gated ones checked here.
      nxt_st.rst_req = POR_REQ | LOW_VOLTAGE_RESET_SOURCE
                       | EXT_PIN_RESET_REQ // [RULE_02]
                       | (OSC_FAIL & st_ff.osc_en
                          & st_ff.osc_mon_rst_en) // [RULE_04]
                       | (WATCHDOG_TIMEOUT
                          & (st_ff.wd_rate != 3'd0)); // [RULE_03]
      // Request to the core; dropped when nothing is pending.
      nxt_st.irq_req = any_pend; // [RULE_14]
      nxt_st.irq_vec = st_ff.vecbase | {15'h0000, win_ofs}; // [RULE_06]
      if (IRQ_ACK && st_ff.irq_req) begin
         ev_set[EV_IRQ_TAKEN] = 1'b1;
      end
      // Set wins over a clear in the same cycle.
      nxt_st.ev_stat = nxt_st.ev_stat | ev_set;
      // Read data for the access phase that follows.
      nxt_st.prdata = 32'h0000_0000;
      if (apb_rd) begin
         if (PADDR == ADDR_VECBASE) begin
            nxt_st.prdata = {8'h00, st_ff.vecbase};
         end else if (PADDR == ADDR_RSTCFG) begin
            nxt_st.prdata = {27'h000_0000, st_ff.osc_mon_rst_en,
                             st_ff.osc_en, st_ff.wd_rate};
         end else if (PADDR == ADDR_IRQEN) begin
            nxt_st.prdata = {10'h000, st_ff.irq_en};
         end else if (PADDR == ADDR_PEND) begin
            nxt_st.prdata = {16'h0000, pend};
         end else if (PADDR == ADDR_VECTOR) begin
            nxt_st.prdata = {st_ff.irq_req, 7'h00, st_ff.irq_vec};
         end else if (PADDR == ADDR_EVSTAT) begin
            nxt_st.prdata = {30'h0000_0000, st_ff.ev_stat};
         end else if (PADDR == ADDR_EVEN) begin
            nxt_st.prdata = {30'h0000_0000, st_ff.ev_en};
         end else if (PADDR == ADDR_SECST) begin
            nxt_st.prdata = {31'h0000_0000, st_ff.secured};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset. Device starts secured.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_ff <= '0;
         st_ff.vecbase <= VECBASE_RST;
         st_ff.secured <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign PRDATA = st_ff.prdata;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~addr_ok;
   assign RESET_REQ = st_ff.rst_req;
   assign RESET_VEC = RESET_VECTOR; // [RULE_02]
   assign SEC_PROG = st_ff.sec_prog;
   assign SEC_VALUE = SEC_UNSECURED;
   assign SECURED = st_ff.secured;
   assign IRQ_REQ = st_ff.irq_req;
   assign IRQ_VECTOR = st_ff.irq_vec;
   assign EVENT_IRQ = |(st_ff.ev_stat & st_ff.ev_en);
endmodule

// *** pkg/rivm_pkg.sv ***
package rivm_pkg;
   // APB register byte addresses.
   localparam logic [11:0] ADDR_VECBASE = 12'h000;
   localparam logic [11:0] ADDR_RSTCFG = 12'h004;
   localparam logic [11:0] ADDR_IRQEN = 12'h008;
   localparam logic [11:0] ADDR_PEND = 12'h00C;
   localparam logic [11:0] ADDR_VECTOR = 12'h010;
   localparam logic [11:0] ADDR_EVSTAT = 12'h014;
   localparam logic [11:0] ADDR_EVEN = 12'h018;
   localparam logic [11:0] ADDR_EVCLR = 12'h01C;
   localparam logic [11:0] ADDR_SECST = 12'h020;
   // Reset vector address.
   localparam logic [19:0] RESET_VECTOR = 20'hF_FFFC;
   // Reset value of the vector base (upper bits of address).
   localparam logic [23:0] VECBASE_RST = 24'hFF_FE00;
   // Width of the arbitrated request vector; sources use indices 0 to 12.
   localparam int NSRC = 16;
   // Source index positions, index 0 has lowest priority.
   localparam int S_DRV_LIM = 0;
   localparam int S_BATMON = 1;
   localparam int S_ADC_AD = 2;
   localparam int S_SERIAL1 = 3;
   localparam int S_SERIAL0 = 4;
   localparam int S_TIM_C3 = 5;
   localparam int S_TIM_C2 = 6;
   localparam int S_TIM_C1 = 7;
   localparam int S_TIM_C0 = 8;
   localparam int S_CALL = 9;
   localparam int S_SOFT_INT = 10;
   localparam int S_TRAP2 = 11;
   localparam int S_TRAP1 = 12;
   // Fixed vector offsets.
   localparam logic [8:0] OFS_TRAP1 = 9'h1F8;
   localparam logic [8:0] OFS_TRAP2 = 9'h1F4;
   localparam logic [8:0] OFS_SOFT_INT = 9'h1F0;
   localparam logic [8:0] OFS_CALL = 9'h1EC;
   localparam logic [8:0] OFS_TIM_C0 = 9'h1CC;
   localparam logic [8:0] OFS_TIM_STEP = 9'h004;
   localparam logic [8:0] OFS_SERIAL0 = 9'h19C;
   localparam logic [8:0] OFS_SERIAL1 = 9'h198;
   localparam logic [8:0] OFS_ADC_AD = 9'h188;
   localparam logic [8:0] OFS_BATMON = 9'h140;
   localparam logic [8:0] OFS_DRV_LIM = 9'h138;
   // Security byte values.
   localparam logic [1:0] SEC_UNSECURED = 2'b10;
   // Event status bit positions.
   localparam int EV_ERASE_OK = 0;
   localparam int EV_IRQ_TAKEN = 1;
   localparam int NEV = 2;
endpackage

// *** verif/reset_irq_vector_map_test.sv ***
`timescale 1ns/1ns
// Self-checking bench: APB master, random sources, arbitration model.
module reset_irq_vector_map_test
   import rivm_pkg::*;
;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err, se, xr;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, rd, st = 32'h2310_b6a5;
   logic [4:0] rsrc = 0, s0 = 0, s1 = 0, cfg;
   logic t1 = 0, t2 = 0, sint = 0, scall = 0, im = 0, ack_en = 0, q;
   logic [3:0] tim = 0;
   logic adc = 0, bh = 0, bl = 0, ed = 0, eok = 0, ack;
   logic [2:0] drv = 0;
   logic prdy, rreq, sprog, secd, ireq, evirq;
   logic [19:0] rvec;
   logic [1:0] sval;
   logic [23:0] ivec, lastv, vb = 24'hFF_FE00;
   logic [21:0] en;
   logic [8:0] o;
   int fail_count = 0, checks_done = 0, cyc = 0;
   int cfgq[$] = '{0, 8, 16, 25, 7};
   ////////////////////////////////////////////////////////////////////////
   rivm_top i_rivm_top(.CLK(clk), .SYS_RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(prdy), .PSLVERR(err), .POR_REQ(rsrc[0]),
      .LOW_VOLTAGE_RESET_SOURCE(rsrc[1]), .EXT_PIN_RESET_REQ(rsrc[2]),
      .OSC_FAIL(rsrc[3]), .WATCHDOG_TIMEOUT(rsrc[4]), .TRAP1_REQ(t1),
      .TRAP2_REQ(t2), .SOFT_INT_REQ(sint), .CALL_INSTR_REQ(scall),
      .I_MASK(im), .IRQ_ACK(ack), .TIM_CH_FLAG(tim),
      .ABORT_DONE_FLAG(adc), .SERIAL0_FLAG(s0), .SERIAL1_FLAG(s1),
      .BAT_HIGH_FLAG(bh), .BAT_LOW_FLAG(bl),
      .DRIVER_FLAG(drv), .ERASE_DONE(ed), .ERASE_OK(eok), .RESET_REQ(rreq),
      .RESET_VEC(rvec), .SEC_PROG(sprog), .SEC_VALUE(sval),
      .SECURED(secd), .IRQ_REQ(ireq), .IRQ_VECTOR(ivec),
      .EVENT_IRQ(evirq));
   rivm_core_model i_rivm_core_model(.clk(clk), .rst(rst), .irq_req(ireq),
      .irq_vector(ivec), .ack_en(ack_en), .irq_ack(ack), .last_vec(lastv));
   ////////////////////////////////////////////////////////////////////////
   // Free-running clock and a cycle ceiling so a hang still ends the run.
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict;
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; waits for ready, never assumes a wait count.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      se = err;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   // Later calls win, so sources are offered lowest offset first.
   task automatic pick(input logic c, input logic [8:0] ofs);
      if (c) begin
         q = 1;
         o = ofs;
      end
   endtask
   task automatic mdl;
      q = 0;
      o = 0;
      if (!im) begin
         pick(|(drv & en[19:17]), 9'h138);
         pick(bh & en[15] | bl & en[16], 9'h140);
         pick(adc & en[4], 9'h188);
         pick(|(s1 & en[14:10]), 9'h198);
         pick(|(s0 & en[9:5]), 9'h19C);
         for (int c = 3; c >= 0; c--) begin
            pick(tim[c] & en[c], 9'h1CC - 9'(4 * c));
         end
      end
      pick(scall, 9'h1EC);
      pick(sint, 9'h1F0);
      pick(t2, 9'h1F4);
      pick(t1, 9'h1F8);
   endtask
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(0, ADDR_VECBASE, 0);
      chk(rd, 32'h00FF_FE00);
      chk(se, 0);
      apb(0, ADDR_SECST, 0);
      chk(rd, 1);
      apb(0, 12'h0FC, 0);
      chk(rd, 0);
      chk(se, 1);
      // Each reset cause under five local configurations.
      foreach (cfgq[p]) begin
         cfg = 5'(cfgq[p]);
         apb(1, ADDR_RSTCFG, {27'h0, cfg});
         for (int i = 0; i < 5; i++) begin
            @(posedge clk) rsrc <= 5'b1 << i;
            @(posedge clk) #1;
            xr = i < 3 || (i == 3 && cfg[3] && cfg[4])
                 || (i == 4 && cfg[2:0] != 0);
            chk(rreq, xr);
            chk(rvec, 20'hF_FFFC);
            @(posedge clk) rsrc <= 0;
            @(posedge clk);
         end
      end
      // Random sources, enables, masks and relocated bases.
      for (int k = 0; k < 300; k++) begin
         if (k % 50 == 0) begin
            st = xs(st);
            vb = {st[23:9], 9'h000};
            apb(1, ADDR_VECBASE, {8'h00, vb});
         end
         st = xs(st);
         en = st[21:0];
         apb(1, ADDR_IRQEN, {10'h000, en});
         st = xs(st);
         {drv, bl, bh, s1, s0, adc, tim} <= st[19:0];
         st = xs(st);
         {im, scall, sint, t2, t1} <= {st[12], &st[11:9], &st[8:6],
                                       &st[5:3], &st[2:0]};
         @(posedge clk);
         @(posedge clk) #1;
         mdl;
         chk(ireq, q);
         if (q) begin
            chk(ivec, {vb[23:9], o});
         end
         @(posedge clk);
         apb(0, ADDR_VECTOR, 0);
         chk(rd[31:24], {q, 7'h00});
         if (q) begin
            chk(rd[23:0], {vb[23:9], o});
         end
      end
      {drv, bl, bh, s1, s0, adc, tim, im, scall, sint, t2, t1} <= 0;
      // Failed erase keeps security, good erase clears it once.
      @(posedge clk) {ed, eok} <= 2'b10;
      @(posedge clk) ed <= 0;
      #1 chk({secd, sprog}, 2'b10);
      @(posedge clk) {ed, eok} <= 2'b11;
      @(posedge clk) ed <= 0;
      #1 chk({secd, sprog, sval}, 4'b0110);
      @(posedge clk) #1 chk(sprog, 0);
      @(posedge clk);
      apb(0, ADDR_SECST, 0);
      chk(rd, 0);
      // Event interrupt: raise, clear, acknowledge, mask.
      apb(1, ADDR_EVEN, 3);
      chk(evirq, 1);
      apb(1, ADDR_EVCLR, 1);
      chk(evirq, 0);
      t1 <= 1;
      ack_en <= 1;
      repeat (4) @(posedge clk);
      {t1, ack_en} <= 0;
      @(posedge clk);
      chk(lastv, {vb[23:9], 9'h1F8});
      apb(0, ADDR_EVSTAT, 0);
      chk({rd[1:0], evirq}, 3'b101);
      apb(1, ADDR_EVEN, 0);
      chk(evirq, 0);
      apb(0, ADDR_EVCLR, 0);
      chk(rd, 0);
      apb(1, ADDR_EVCLR, 2);
      apb(0, ADDR_EVSTAT, 0);
      chk(rd, 0);
      give_verdict;
   end
endmodule

// *** verif/rivm_checker.sv ***
`timescale 1ns/1ns
// Watches reset, security and vector outputs against their causes.
module rivm_checker
   import rivm_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic POR_REQ,
   input wire logic LOW_VOLTAGE_RESET_SOURCE,
   input wire logic EXT_PIN_RESET_REQ,
   input wire logic TRAP1_REQ,
   input wire logic TRAP2_REQ,
   input wire logic SOFT_INT_REQ,
   input wire logic CALL_INSTR_REQ,
   input wire logic I_MASK,
   input wire logic ERASE_DONE,
   input wire logic ERASE_OK,
   input wire logic RESET_REQ,
   input wire logic [19:0] RESET_VEC,
   input wire logic SEC_PROG,
   input wire logic [1:0] SEC_VALUE,
   input wire logic SECURED,
   input wire logic IRQ_REQ,
   input wire logic [23:0] IRQ_VECTOR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   AST_RST_SRC: assert property (
      (POR_REQ | LOW_VOLTAGE_RESET_SOURCE | EXT_PIN_RESET_REQ) |=> RESET_REQ)
      else $error("Reset cause gave no reset request.");
   AST_RST_VEC: assert property (RESET_VEC == 20'hF_FFFC)
      else $error("Reset vector is wrong.");
   AST_ERASE: assert property (
      ERASE_DONE && ERASE_OK |=> SEC_PROG && !SECURED ##1 !SEC_PROG)
      else $error("Good erase did not unsecure once.");
   AST_SEC_VAL: assert property (SEC_PROG |-> SEC_VALUE == 2'b10)
      else $error("Security byte value is wrong.");
   AST_TRAP1: assert property (
      TRAP1_REQ |=> IRQ_REQ && IRQ_VECTOR[8:0] == 9'h1F8)
      else $error("First trap not taken.");
   AST_TRAP2: assert property (
      TRAP2_REQ && !TRAP1_REQ |=> IRQ_REQ && IRQ_VECTOR[8:0] == 9'h1F4)
      else $error("Second trap not taken.");
   AST_SOFT_INT: assert property (
      SOFT_INT_REQ && !(TRAP1_REQ | TRAP2_REQ) |=> IRQ_VECTOR[8:0] == 9'h1F0)
      else $error("Software interrupt not taken.");
   AST_CALL_INSTR: assert property (
      CALL_INSTR_REQ && !(TRAP1_REQ | TRAP2_REQ | SOFT_INT_REQ)
      |=> IRQ_REQ && IRQ_VECTOR[8:0] == 9'h1EC)
      else $error("System call not taken.");
   AST_NOREQ: assert property (
      I_MASK && !(TRAP1_REQ | TRAP2_REQ | SOFT_INT_REQ | CALL_INSTR_REQ)
      |=> !IRQ_REQ)
      else $error("Request shown with nothing pending.");
endmodule
bind rivm_top rivm_checker i_rivm_checker(.CLK, .SYS_RST, .POR_REQ,
   .LOW_VOLTAGE_RESET_SOURCE, .EXT_PIN_RESET_REQ, .TRAP1_REQ, .TRAP2_REQ,
   .SOFT_INT_REQ, .CALL_INSTR_REQ, .I_MASK, .ERASE_DONE, .ERASE_OK,
   .RESET_REQ, .RESET_VEC, .SEC_PROG, .SEC_VALUE, .SECURED, .IRQ_REQ,
   .IRQ_VECTOR);

// *** verif/rivm_core_model.sv ***
`timescale 1ns/1ns
// Core side: takes a presented request every other cycle while ack_en is high and keeps the fetched vector.
module rivm_core_model
   import rivm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic [23:0] irq_vector,
   input wire logic ack_en,
   output logic irq_ack,
   output logic [23:0] last_vec
);
   // One-cycle acknowledge pulses, never two in a row, as a real core.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_ack <= 1'b0;
         last_vec <= 24'h00_0000;
      end else begin
         irq_ack <= irq_req && ack_en && !irq_ack;
         if (irq_req && ack_en && !irq_ack) begin
            last_vec <= irq_vector;
         end
      end
   end
endmodule
